// ### shared/fcoc_pkg.sv
// What this block does
// - soft and hardware resets copy stored options into working copy, RST clears it
// - stored option bits program once, never back
// - both registers served by generic read/write opcodes
// - bits 7:6 reserved, stored copy erased zero
// - bit 5 enables blank check before erase
// - failed previous erase means unconditional erase
// - zero found starts erase, blank skips it
// - blank check covers parameter, sector, bulk erase
// - check disabled: erase starts at once if engine idle and no reload comes with it
// - 256 mode: load address wraps to zero
// - bit 3 removes the 4-kB parameter sectors
// - working bit 3 read-only, mirrors stored bit unless a reload meets a stored write
// - bit 2: 30h resume, else clear status
// - bit 1: D8h/DCh erase 256 kB else 64 kB
// - bit 0 enables F0h reset, else ignored
// - 66h then 99h always resets
package fcoc_pkg;

	// ****************************************
	// command opcodes
	// ****************************************
	localparam logic [7:0] OP_READ_ANY      = 8'h65;
	localparam logic [7:0] OP_WRITE_ANY     = 8'h71;
	localparam logic [7:0] OP_PAGE_PROG     = 8'h02;
	localparam logic [7:0] OP_PARAM_ERASE   = 8'h20;
	localparam logic [7:0] OP_SECT_ERASE    = 8'hD8;
	localparam logic [7:0] OP_SECT_ERASE_4B = 8'hDC;
	localparam logic [7:0] OP_BULK_ERASE    = 8'h60;
	localparam logic [7:0] OP_BULK_ERASE_2  = 8'hC7;
	localparam logic [7:0] OP_CLR_RESUME    = 8'h30;
	localparam logic [7:0] OP_LEGACY_RESET  = 8'hF0;
	localparam logic [7:0] OP_RESET_ENABLE  = 8'h66;
	localparam logic [7:0] OP_RESET         = 8'h99;

	// ****************************************
	// register map and fields
	// ****************************************
	localparam logic [23:0] ADDR_OPT_NV      = 24'h000004;
	localparam logic [23:0] ADDR_OPT_WORK    = 24'h800004;
	localparam logic [7:0]  OPT_NV_RESET     = 8'h00;
	localparam logic [7:0]  OPT_WORK_RESET   = 8'h00;
	localparam logic [7:0]  OPT_DEFINED_MASK = 8'h3F;
	localparam logic [7:0]  OPT_WORK_WR_MASK = 8'h37;
	localparam int          OPT_BLANK_CHECK  = 5;
	localparam int          OPT_PAGE_WRAP    = 4;
	localparam int          OPT_PARAM_DIS    = 3;
	localparam int          OPT_RESUME_SEL   = 2;
	localparam int          OPT_BLOCK_SIZE   = 1;
	localparam int          OPT_LEGACY_RST   = 0;
	localparam logic [1:0]  ADDR_LAST_BYTE   = 2'd2;
	localparam logic [7:0]  BUF_LAST_256     = 8'hFF;
	localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		FCOC_ST_IDLE = 2'b00,
		FCOC_ST_ADDR = 2'b01,
		FCOC_ST_DATA = 2'b11,
		FCOC_ST_HOLD = 2'b10
	} fcoc_cmd_state_e;

	typedef enum logic {
		FCOC_ER_IDLE = 1'b0,
		FCOC_ER_SCAN = 1'b1
	} fcoc_erase_state_e;

	typedef enum logic [1:0] {
		FCOC_EK_PARAM  = 2'b00,
		FCOC_EK_SECTOR = 2'b01,
		FCOC_EK_BULK   = 2'b10
	} fcoc_erase_kind_e;

	typedef enum logic [1:0] {
		FCOC_SEL_NONE = 2'b00,
		FCOC_SEL_NV   = 2'b01,
		FCOC_SEL_WORK = 2'b10
	} fcoc_reg_sel_e;

endpackage

// ### src/fcoc_otp_bits.sv
`timescale 1ns/100ps
`default_nettype none
module fcoc_otp_bits (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// programming
	input  wire logic       prog,
	input  wire logic [7:0] prog_data,
	input  wire logic [7:0] prog_mask,
	// stored value
	output logic      [7:0] q
);
	import fcoc_pkg::*;

	genvar i;
	generate
		for (i = 0; i < 8; i++) begin : g_bit
			// a bit only ever moves away from its erased zero
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					q[i] <= OPT_NV_RESET[i];
				end else if (prog && prog_mask[i] && prog_data[i]) begin
					q[i] <= 1'b1;
				end
			end
		end
	endgenerate

	otp_no_clear_a: assert property (
		@(posedge clk) disable iff (rst)
		(q & $past(q)) == $past(q)
	) else $error("programmed option bit returned to erased state");

	otp_reserved_a: assert property (
		@(posedge clk) disable iff (rst)
		q[7:6] == 2'b00
	) else $error("reserved stored option bit set");
endmodule
`default_nettype wire

// ### src/fcoc_spi_shift.sv
`timescale 1ns/100ps
`default_nettype none
module fcoc_spi_shift (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// serial pins, mode 0, sampled on clk
	input  wire logic       sck,
	input  wire logic       cs_n,
	input  wire logic       si,
	output logic            so,
	output logic            so_oe,
	// byte side
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	output logic            rx_valid,
	output logic            cs_rise
);
	logic       sck_q;
	logic       cs_q;
	logic [2:0] cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] tx_q;
	logic       sck_up;
	logic       sck_dn;

	assign sck_up  = sck && !sck_q && !cs_n;
	assign sck_dn  = !sck && sck_q && !cs_n;
	assign cs_rise = cs_n && !cs_q;
	assign so      = tx_q[7];
	assign so_oe   = !cs_n;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
			cs_q  <= 1'b1;
		end else begin
			sck_q <= sck;
			cs_q  <= cs_n;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q    <= 3'd0;
			rx_sh_q  <= 7'h00;
			rx_byte  <= 8'h00;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			if (cs_n) begin
				cnt_q <= 3'd0;
			end else if (sck_up) begin
				rx_sh_q <= {rx_sh_q[5:0], si};
				cnt_q   <= cnt_q + 3'd1;
				if (cnt_q == 3'd7) begin
					rx_byte  <= {rx_sh_q, si};
					rx_valid <= 1'b1;
				end
			end
		end
	end

	// reply byte is taken at the falling edge that closes a byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_q <= 8'h00;
		end else if (cs_n) begin
			tx_q <= 8'h00;
		end else if (sck_dn) begin
			if (cnt_q == 3'd0) begin
				tx_q <= tx_byte;
			end else begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
		end
	end

	byte_strobe_a: assert property (
		@(posedge clk) disable iff (rst)
		rx_valid |-> $past(sck_up) && $past(cnt_q) == 3'd7
	) else $error("byte strobe without eighth edge");
endmodule
`default_nettype wire

// ### src/fcoc_top.sv
`timescale 1ns/100ps
`default_nettype none
module fcoc_top (
	// clock and reset
	input  wire logic                   CLOCK,
	input  wire logic                   RST,
	input  wire logic                   HW_RESET,
	// serial host pins
	input  wire logic                   SCK,
	input  wire logic                   CS_N,
	input  wire logic                   SI,
	output logic                        SO,
	output logic                        SO_OE,
	// working option levels
	output logic                        BLANK_CHECK_ENABLE,
	output logic                        PAGE_BUF_WRAP_SEL,
	output logic                        PARAM_SECTOR_DISABLE,
	output logic                        RESUME_OPCODE_SEL,
	output logic                        BLOCK_ERASE_SIZE_SEL,
	output logic                        LEGACY_RESET_ENABLE,
	// command pulses
	output logic                        SOFT_RESET,
	output logic                        CLEAR_STATUS,
	output logic                        PROG_ERASE_RESUME,
	// page buffer load
	output logic                        BUF_WE,
	output logic [8:0]                  BUF_ADDR,
	output logic [7:0]                  BUF_DATA,
	// erase engine
	output logic                        ERASE_START,
	output fcoc_pkg::fcoc_erase_kind_e  ERASE_KIND,
	output logic [23:0]                 ERASE_ADDR,
	output logic                        ERASE_SKIPPED,
	output logic                        BLANK_SCAN_REQ,
	input  wire logic                   SECTOR_ERASE_OK,
	input  wire logic                   SCAN_ZERO_FOUND,
	input  wire logic                   SCAN_BLANK
);
	import fcoc_pkg::*;

	// ****************************************
	// decode helpers
	// ****************************************
	function automatic fcoc_reg_sel_e reg_sel(input logic [23:0] a);
		if (a == ADDR_OPT_NV) begin
			reg_sel = FCOC_SEL_NV;
		end else if (a == ADDR_OPT_WORK) begin
			reg_sel = FCOC_SEL_WORK;
		end else begin
			reg_sel = FCOC_SEL_NONE;
		end
	endfunction

	function automatic logic is_erase(input logic [7:0] op);
		is_erase = (op == OP_PARAM_ERASE) || (op == OP_SECT_ERASE) ||
			(op == OP_SECT_ERASE_4B) || (op == OP_BULK_ERASE) || (op == OP_BULK_ERASE_2);
	endfunction

	function automatic logic has_addr(input logic [7:0] op);
		has_addr = (op == OP_READ_ANY) || (op == OP_WRITE_ANY) || (op == OP_PAGE_PROG) ||
			(op == OP_PARAM_ERASE) || (op == OP_SECT_ERASE) || (op == OP_SECT_ERASE_4B);
	endfunction

	// ****************************************
	// serial shifter and stored options
	// ****************************************
	logic [7:0] rx_byte;
	logic       rx_valid;
	logic       cs_rise;
	logic [7:0] rd_data_q;
	logic [7:0] wdata_q;
	logic [7:0] nv_bits;
	logic [7:0] work_q;
	logic       nv_prog;

	fcoc_spi_shift u_shift (
		.clk      (CLOCK),
		.rst      (RST),
		.sck      (SCK),
		.cs_n     (CS_N),
		.si       (SI),
		.so       (SO),
		.so_oe    (SO_OE),
		.tx_byte  (rd_data_q),
		.rx_byte  (rx_byte),
		.rx_valid (rx_valid),
		.cs_rise  (cs_rise)
	);

	fcoc_otp_bits u_otp (
		.clk       (CLOCK),
		.rst       (RST),
		.prog      (nv_prog),
		.prog_data (wdata_q),
		.prog_mask (OPT_DEFINED_MASK),
		.q         (nv_bits)
	);

	// ****************************************
	// command framing
	// ****************************************
	fcoc_cmd_state_e state_q;
	logic [7:0]      cmd_q;
	logic [23:0]     addr_q;
	logic [1:0]      addr_cnt_q;
	logic            wdata_vld_q;
	logic            exec;
	logic            addr_done;
	fcoc_reg_sel_e   wr_sel;

	assign exec      = cs_rise && (state_q != FCOC_ST_IDLE);
	assign addr_done = rx_valid && (state_q == FCOC_ST_ADDR) && (addr_cnt_q == ADDR_LAST_BYTE);
	assign wr_sel    = reg_sel(addr_q);
	assign nv_prog   = exec && (cmd_q == OP_WRITE_ANY) && wdata_vld_q &&
		(wr_sel == FCOC_SEL_NV);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state_q    <= FCOC_ST_IDLE;
			cmd_q      <= 8'h00;
			addr_q     <= 24'h000000;
			addr_cnt_q <= 2'd0;
		end else if (CS_N) begin
			state_q    <= FCOC_ST_IDLE;
			addr_cnt_q <= 2'd0;
		end else if (rx_valid) begin
			case (state_q)
				FCOC_ST_IDLE: begin
					cmd_q   <= rx_byte;
					state_q <= has_addr(rx_byte) ? FCOC_ST_ADDR : FCOC_ST_HOLD;
				end
				FCOC_ST_ADDR: begin
					addr_q     <= {addr_q[15:0], rx_byte};
					addr_cnt_q <= addr_cnt_q + 2'd1;
					if (addr_cnt_q == ADDR_LAST_BYTE) begin
						state_q <= FCOC_ST_DATA;
					end
				end
				FCOC_ST_DATA: state_q <= FCOC_ST_DATA;
				FCOC_ST_HOLD: state_q <= FCOC_ST_HOLD;
				default: state_q <= FCOC_ST_IDLE;
			endcase
		end
	end

	// only the first data byte of a register write counts
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			wdata_q     <= 8'h00;
			wdata_vld_q <= 1'b0;
		end else if (state_q == FCOC_ST_IDLE) begin
			wdata_vld_q <= 1'b0;
		end else if (rx_valid && (state_q == FCOC_ST_DATA) && (cmd_q == OP_WRITE_ANY) &&
			!wdata_vld_q) begin
			wdata_q     <= rx_byte;
			wdata_vld_q <= 1'b1;
		end
	end

	// ****************************************
	// register read path
	// ****************************************
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rd_data_q <= READ_UNMAPPED;
		end else if (addr_done || (rx_valid && state_q == FCOC_ST_DATA)) begin
			case (reg_sel(addr_done ? {addr_q[15:0], rx_byte} : addr_q))
				FCOC_SEL_NV:   rd_data_q <= nv_bits & OPT_DEFINED_MASK;
				FCOC_SEL_WORK: rd_data_q <= work_q & OPT_DEFINED_MASK;
				default:       rd_data_q <= READ_UNMAPPED;
			endcase
		end
	end

	// ****************************************
	// working option copy
	// ****************************************
	logic reload;
	logic soft_rst_q;

	assign reload = soft_rst_q || HW_RESET;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			work_q <= OPT_WORK_RESET;
		end else if (reload) begin
			work_q <= nv_bits & OPT_DEFINED_MASK;
		end else if (nv_prog) begin
			// parameter-sector bit follows its stored bit only
			work_q[OPT_PARAM_DIS] <= nv_bits[OPT_PARAM_DIS] | wdata_q[OPT_PARAM_DIS];
		end else if (exec && (cmd_q == OP_WRITE_ANY) && wdata_vld_q &&
			(wr_sel == FCOC_SEL_WORK)) begin
			work_q <= (work_q & ~OPT_WORK_WR_MASK) | (wdata_q & OPT_WORK_WR_MASK);
		end
	end

	assign BLANK_CHECK_ENABLE   = work_q[OPT_BLANK_CHECK];
	assign PAGE_BUF_WRAP_SEL    = work_q[OPT_PAGE_WRAP];
	assign PARAM_SECTOR_DISABLE = work_q[OPT_PARAM_DIS];
	assign RESUME_OPCODE_SEL    = work_q[OPT_RESUME_SEL];
	assign BLOCK_ERASE_SIZE_SEL = work_q[OPT_BLOCK_SIZE];
	assign LEGACY_RESET_ENABLE  = work_q[OPT_LEGACY_RST];

	// ****************************************
	// single-byte commands and resets
	// ****************************************
	logic armed_q;
	logic clr_q;
	logic resume_q;

	// any completed command other than 66h disarms the pair
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			armed_q    <= 1'b0;
			soft_rst_q <= 1'b0;
			clr_q      <= 1'b0;
			resume_q   <= 1'b0;
		end else begin
			soft_rst_q <= 1'b0;
			clr_q      <= 1'b0;
			resume_q   <= 1'b0;
			if (exec && state_q == FCOC_ST_HOLD) begin
				armed_q <= (cmd_q == OP_RESET_ENABLE);
				if (cmd_q == OP_RESET && armed_q) begin
					soft_rst_q <= 1'b1;
				end
				if (cmd_q == OP_LEGACY_RESET && work_q[OPT_LEGACY_RST]) begin
					soft_rst_q <= 1'b1;
				end
				if (cmd_q == OP_CLR_RESUME) begin
					resume_q <= work_q[OPT_RESUME_SEL];
					clr_q    <= !work_q[OPT_RESUME_SEL];
				end
			end else if (exec) begin
				armed_q <= 1'b0;
			end
		end
	end

	assign SOFT_RESET        = soft_rst_q;
	assign CLEAR_STATUS      = clr_q;
	assign PROG_ERASE_RESUME = resume_q;

	// ****************************************
	// page buffer loading
	// ****************************************
	logic [8:0] ptr_q;
	logic [8:0] ptr_next;

	assign ptr_next = work_q[OPT_PAGE_WRAP] ? ptr_q + 9'd1 :
		{1'b0, ptr_q[7:0] + 8'd1};

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ptr_q    <= 9'h000;
			BUF_WE   <= 1'b0;
			BUF_ADDR <= 9'h000;
			BUF_DATA <= 8'h00;
		end else begin
			BUF_WE <= 1'b0;
			if (addr_done && cmd_q == OP_PAGE_PROG) begin
				ptr_q <= work_q[OPT_PAGE_WRAP] ? {addr_q[0], rx_byte} :
					{1'b0, rx_byte};
			end else if (rx_valid && state_q == FCOC_ST_DATA && cmd_q == OP_PAGE_PROG) begin
				BUF_WE   <= 1'b1;
				BUF_ADDR <= ptr_q;
				BUF_DATA <= rx_byte;
				ptr_q    <= ptr_next;
			end
		end
	end

	// ****************************************
	// erase launch with blank check
	// ****************************************
	fcoc_erase_state_e er_state_q;
	logic              erase_kick;

	// sector kinds need their address, bulk needs none
	assign erase_kick = exec && is_erase(cmd_q) &&
		(state_q == FCOC_ST_DATA || state_q == FCOC_ST_HOLD);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			er_state_q    <= FCOC_ER_IDLE;
			ERASE_START   <= 1'b0;
			ERASE_SKIPPED <= 1'b0;
			ERASE_KIND    <= FCOC_EK_PARAM;
			ERASE_ADDR    <= 24'h000000;
		end else begin
			ERASE_START   <= 1'b0;
			ERASE_SKIPPED <= 1'b0;
			case (er_state_q)
				FCOC_ER_IDLE: begin
					if (erase_kick && !reload) begin
						ERASE_ADDR <= addr_q;
						if (cmd_q == OP_PARAM_ERASE) begin
							ERASE_KIND <= FCOC_EK_PARAM;
						end else if (cmd_q == OP_SECT_ERASE || cmd_q == OP_SECT_ERASE_4B) begin
							ERASE_KIND <= FCOC_EK_SECTOR;
						end else begin
							ERASE_KIND <= FCOC_EK_BULK;
						end
						if (work_q[OPT_BLANK_CHECK] && SECTOR_ERASE_OK) begin
							er_state_q <= FCOC_ER_SCAN;
						end else begin
							ERASE_START <= 1'b1;
						end
					end
				end
				FCOC_ER_SCAN: begin
					if (reload) begin
						er_state_q <= FCOC_ER_IDLE;
					end else if (SCAN_ZERO_FOUND) begin
						ERASE_START <= 1'b1;
						er_state_q  <= FCOC_ER_IDLE;
					end else if (SCAN_BLANK) begin
						ERASE_SKIPPED <= 1'b1;
						er_state_q    <= FCOC_ER_IDLE;
					end
				end
				default: er_state_q <= FCOC_ER_IDLE;
			endcase
		end
	end

	assign BLANK_SCAN_REQ = (er_state_q == FCOC_ER_SCAN);

	// ****************************************
	// checks
	// ****************************************
	reload_copy_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		reload && !nv_prog |=> work_q == (nv_bits & OPT_DEFINED_MASK)
	) else $error("working copy not loaded from stored copy");

	param_mirror_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		##1 work_q[OPT_PARAM_DIS] == nv_bits[OPT_PARAM_DIS]
	) else $error("parameter-sector bit differs from stored bit");

	reserved_zero_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		work_q[7:6] == 2'b00 && rd_data_q[7:6] == 2'b00
	) else $error("reserved option bit visible");

	direct_erase_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		erase_kick && !reload && er_state_q == FCOC_ER_IDLE && !work_q[OPT_BLANK_CHECK]
		|=> ERASE_START && !BLANK_SCAN_REQ
	) else $error("erase without blank check did not start");

	failed_erase_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		erase_kick && !reload && er_state_q == FCOC_ER_IDLE && !SECTOR_ERASE_OK
		|=> ERASE_START
	) else $error("sector with failed erase not erased");

	blank_skip_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		BLANK_SCAN_REQ && !reload && !SCAN_ZERO_FOUND && SCAN_BLANK
		|=> ERASE_SKIPPED && !ERASE_START && !BLANK_SCAN_REQ
	) else $error("blank sector not skipped");

	wrap_256_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		BUF_WE && !PAGE_BUF_WRAP_SEL |-> BUF_ADDR[8] == 1'b0 &&
			(BUF_ADDR[7:0] != BUF_LAST_256 || ptr_q == 9'h000)
	) else $error("buffer load did not wrap at 256");

	legacy_ignore_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		exec && state_q == FCOC_ST_HOLD && cmd_q == OP_LEGACY_RESET && !LEGACY_RESET_ENABLE
		|=> !SOFT_RESET
	) else $error("disabled legacy reset acted");

	pair_reset_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		exec && state_q == FCOC_ST_HOLD && cmd_q == OP_RESET && armed_q
		|=> SOFT_RESET ##1 work_q == (nv_bits & OPT_DEFINED_MASK)
	) else $error("reset pair did not reset");

	decode_30_a: assert property (
		@(posedge CLOCK) disable iff (RST)
		exec && state_q == FCOC_ST_HOLD && cmd_q == OP_CLR_RESUME
		|=> PROG_ERASE_RESUME == $past(RESUME_OPCODE_SEL) && CLEAR_STATUS != PROG_ERASE_RESUME
	) else $error("30h decoded wrongly");
endmodule
`default_nettype wire

// ### tb/fcoc_host.sv
`timescale 1ns/100ps
`default_nettype none
module fcoc_host (
	// clock
	input  wire logic clk,
	// serial pins
	output logic      sck,
	output logic      cs_n,
	output logic      si,
	input  wire logic so
);
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// ****************
	// serial frame
	// ****************
	// four clocks per phase: the device oversamples the pins
	task automatic wait4;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// opcode, na address bytes, nd data bytes counting up from d
	task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int na,
		input logic [7:0] d, input int nd, output logic [7:0] rx);
		logic [7:0] b;
		@(posedge clk);
		#1 cs_n = 1'b0;
		for (int k = 0; k < 1 + na + nd; k++) begin
			b = (k == 0) ? op : (k <= na) ? ad[8*(na-k) +: 8] : d + 8'(k - na - 1);
			for (int i = 7; i >= 0; i--) begin
				si = b[i];
				wait4();
				sck = 1'b1;
				rx[i] = so;
				wait4();
				sck = 1'b0;
			end
		end
		wait4();
		cs_n = 1'b1;
		// released line: no stale value left behind
		si = ~si;
		wait4();
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import fcoc_pkg::*;
	// ****************
	// design and host
	// ****************
	logic             clock = 1'b0;
	logic             rst = 1'b1;
	logic             hw_reset = 1'b0;
	logic             erase_ok = 1'b0;
	logic             zero_found = 1'b0;
	logic             blank = 1'b0;
	logic             sck, cs_n, si, so, scan_req, so_oe;
	logic [23:0]      eaddr;
	wire logic [5:0]  opts, pul;
	logic [8:0]       baddr, last_addr;
	logic [7:0]       bdata, last_data, v;
	fcoc_erase_kind_e kind, last_kind;
	int               cnt [6] = '{default: 0};
	int               ex [6] = '{default: 0};
	int               err_count = 0;
	int               checked = 0;
	// written value, expected readback; host keeps bit 3 equal to the stored bit
	logic [15:0]      rows [6] = '{16'h3737, 16'hF737, 16'h0000, 16'h1515, 16'h6222, 16'hC000};
	logic [7:0]       eops [3] = '{OP_PARAM_ERASE, OP_SECT_ERASE, OP_BULK_ERASE};
	fcoc_erase_kind_e ekind [3] = '{FCOC_EK_PARAM, FCOC_EK_SECTOR, FCOC_EK_BULK};

	always #10 clock = ~clock;

	fcoc_host fcoc_host_inst (.clk(clock), .sck(sck), .cs_n(cs_n), .si(si), .so(so));

	fcoc_top fcoc_top_inst (
		.CLOCK(clock), .RST(rst), .HW_RESET(hw_reset), .SCK(sck), .CS_N(cs_n), .SI(si),
		.SO(so), .SO_OE(so_oe), .BLANK_CHECK_ENABLE(opts[5]), .PAGE_BUF_WRAP_SEL(opts[4]),
		.PARAM_SECTOR_DISABLE(opts[3]), .RESUME_OPCODE_SEL(opts[2]),
		.BLOCK_ERASE_SIZE_SEL(opts[1]), .LEGACY_RESET_ENABLE(opts[0]), .SOFT_RESET(pul[5]),
		.CLEAR_STATUS(pul[4]), .PROG_ERASE_RESUME(pul[3]), .BUF_WE(pul[0]), .BUF_ADDR(baddr),
		.BUF_DATA(bdata), .ERASE_START(pul[2]), .ERASE_KIND(kind), .ERASE_ADDR(eaddr),
		.ERASE_SKIPPED(pul[1]), .BLANK_SCAN_REQ(scan_req), .SECTOR_ERASE_OK(erase_ok),
		.SCAN_ZERO_FOUND(zero_found), .SCAN_BLANK(blank));

	// pulses are counted, so a missing or extra one both show
	always @(posedge clock) begin
		for (int i = 0; i < 6; i++)
			cnt[i] += int'(pul[i] === 1'b1);
		if (pul[0] === 1'b1) begin
			last_addr <= baddr;
			last_data <= bdata;
		end
		if (pul[2] === 1'b1)
			last_kind <= kind;
	end

	// ****************
	// tasks
	// ****************
	task automatic cmp(input logic [8:0] got, input logic [8:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cnt;
		for (int i = 0; i < 6; i++) begin
			checked++;
			if (cnt[i] != ex[i]) begin
				err_count++;
				$display("BAD t=%0t got=%h exp=%h", $time, cnt[i], ex[i]);
			end
		end
	endtask

	task automatic rd(input logic [23:0] a, output logic [7:0] d);
		fcoc_host_inst.frame(OP_READ_ANY, a, 3, 8'h00, 1, d);
	endtask

	task automatic wr(input logic [23:0] a, input logic [7:0] d);
		fcoc_host_inst.frame(OP_WRITE_ANY, a, 3, d, 1, v);
	endtask

	task automatic cmd(input logic [7:0] op, input int na);
		fcoc_host_inst.frame(op, 24'h000000, na, 8'h00, 0, v);
	endtask

	task automatic chk_work(input logic [7:0] e);
		rd(ADDR_OPT_WORK, v);
		cmp(9'(v), 9'(e));
		cmp(9'(opts), 9'(e[5:0]));
	endtask

	task automatic final_report;
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************
	// tests
	// ****************
	initial begin
		#1000000;
		err_count++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		chk_work(8'h00);
		cmp(9'(so_oe), 9'h000);
		rd(ADDR_OPT_NV, v);
		cmp(9'(v), 9'(OPT_NV_RESET));
		rd(24'h000005, v);
		cmp(9'(v), 9'(READ_UNMAPPED));
		$display("test reset done");
		foreach (rows[i]) begin
			wr(ADDR_OPT_WORK, rows[i][15:8]);
			chk_work(rows[i][7:0]);
		end
		$display("test rows done");
		cmd(OP_CLR_RESUME, 0);
		ex[4]++;
		chk_cnt();
		wr(ADDR_OPT_WORK, 8'h04);
		cmd(OP_CLR_RESUME, 0);
		ex[3]++;
		cmd(OP_LEGACY_RESET, 0);
		chk_cnt();
		chk_work(8'h04);
		wr(ADDR_OPT_WORK, 8'h05);
		cmd(OP_LEGACY_RESET, 0);
		ex[5]++;
		chk_cnt();
		chk_work(8'h00);
		wr(ADDR_OPT_WORK, 8'h04);
		cmd(OP_RESET_ENABLE, 0);
		cmd(OP_RESET, 0);
		ex[5]++;
		chk_cnt();
		chk_work(8'h00);
		cmd(OP_RESET_ENABLE, 0);
		cmd(OP_CLR_RESUME, 0);
		cmd(OP_RESET, 0);
		ex[4]++;
		chk_cnt();
		$display("test commands done");
		wr(ADDR_OPT_NV, 8'hC9);
		rd(ADDR_OPT_NV, v);
		cmp(9'(v), 9'h009);
		chk_work(8'h08);
		wr(ADDR_OPT_NV, 8'h00);
		rd(ADDR_OPT_NV, v);
		cmp(9'(v), 9'h009);
		wr(ADDR_OPT_WORK, 8'h08);
		chk_work(8'h08);
		@(posedge clock);
		#1 hw_reset = 1'b1;
		@(posedge clock);
		#1 hw_reset = 1'b0;
		chk_work(8'h09);
		$display("test stored done");
		fcoc_host_inst.frame(OP_PAGE_PROG, 24'h0000FE, 3, 8'hA0, 3, v);
		ex[0] += 3;
		chk_cnt();
		cmp(last_addr, 9'h000);
		cmp(9'(last_data), 9'h0A2);
		wr(ADDR_OPT_WORK, 8'h19);
		fcoc_host_inst.frame(OP_PAGE_PROG, 24'h0000FE, 3, 8'hA0, 3, v);
		ex[0] += 3;
		chk_cnt();
		cmp(last_addr, 9'h100);
		$display("test page done");
		wr(ADDR_OPT_WORK, 8'h09);
		foreach (eops[i]) begin
			cmd(eops[i], (i == 2) ? 0 : 3);
			ex[2]++;
			chk_cnt();
			cmp(9'(last_kind), 9'(ekind[i]));
		end
		wr(ADDR_OPT_WORK, 8'h29);
		fcoc_host_inst.frame(OP_SECT_ERASE_4B, 24'h040123, 3, 8'h00, 0, v);
		ex[2]++;
		chk_cnt();
		cmp(eaddr[8:0], 9'h123);
		cmp(eaddr[23:15], 9'h008);
		erase_ok = 1'b1;
		for (int i = 0; i < 6; i++) begin
			cmd(eops[i % 3], (i % 3 == 2) ? 0 : 3);
			chk_cnt();
			cmp(9'(scan_req), 9'h001);
			zero_found = (i < 3);
			blank = (i >= 3);
			@(posedge clock);
			#1 zero_found = 1'b0;
			blank = 1'b0;
			repeat (2) @(posedge clock);
			ex[(i < 3) ? 2 : 1]++;
			chk_cnt();
			cmp(9'(scan_req), 9'h000);
		end
		$display("test erase done");
		final_report();
	end
endmodule
`default_nettype wire
